// ### include/rtx_defines.svh
/*
 * Register indices, field positions, reset values and timing figures for
 * the radio transmitter configuration and buffer registers.
 * Assumes: included by bare name; byte address is four times the index.
 */
`ifndef RTX_DEFINES_SVH
`define RTX_DEFINES_SVH

// ---------------------------------------------------------------------
// register indices (byte address = index * 4)
// ---------------------------------------------------------------------
`define RTX_IDX_DIRECT_CTRL  16'h1836
`define RTX_IDX_SOFT_RESET   16'h1837
`define RTX_IDX_SPACE_HI     16'h1838
`define RTX_IDX_SPACE_LO     16'h1839
`define RTX_IDX_MARK_HI      16'h183A
`define RTX_IDX_MARK_LO      16'h183B
`define RTX_IDX_BUF_FIRST    16'h183C
`define RTX_IDX_BUF_LAST     16'h185B

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define RTX_LO_FREQ_MSB      7
`define RTX_LO_FREQ_LSB      3
`define RTX_POL_BIT          2
`define RTX_CODE_MSB         1
`define RTX_CODE_LSB         0
`define RTX_BAND_BIT         2
`define RTX_KEY_BIT          1
`define RTX_REF_CLOCK_OUT_EN_BIT        0
`define RTX_DIRECT_BIT       0
`define RTX_SOFT_RESET_BIT   0

// ---------------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------------
`define RTX_FREQ_RESET       13'h0000
`define RTX_BYTE_RESET       8'h00
`define RTX_XTAL_KHZ         26000
`define RTX_REF_KHZ          500

`endif

// ### include/rtx_pkg.sv
/*
 * Types shared by the radio transmitter register block.
 * Assumes: nothing beyond a SystemVerilog compiler.
 */
package rtx_pkg;

    // data encoding and source selection
    typedef enum logic [1:0] {
        RTX_CODE_MANCHESTER = 2'h0,
        RTX_CODE_BIPHASE    = 2'h1,
        RTX_CODE_NRZ        = 2'h2,
        RTX_CODE_DIRECT     = 2'h3
    } rtx_code_type;

    // axi response codes
    typedef enum logic [1:0] {
        RTX_RESP_OKAY   = 2'h0,
        RTX_RESP_SLVERR = 2'h2
    } rtx_resp_type;

endpackage : rtx_pkg

// ### logic/rtx_regs.sv
/*
 * Radio transmitter configuration and transmit buffer registers behind an
 * AXI4-Lite slave, with the modulation source mux and the reference clock
 * divider that these settings steer.
 * Assumes: aclk 100 MHz; xtal_in is an asynchronous crystal-rate pin;
 * serial_bit and tx_on come from a serializer on aclk.
 */
`timescale 1ns/1ps
`include "rtx_defines.svh"

// Behaviour
// R1 - the 13-bit space word sets the 0 carrier, xtal*(12+4*band+word/8192).
// R2 - the space word is zero after power-on reset and after a soft reset.
// R3 - the 13-bit mark word sets the 1 carrier with the same scaling.
// R4 - in on-off keying a 1 emits the mark carrier and a 0 emits no carrier.
// R5 - the inversion bit at position 2 inverts every encoding, direct too.
// R6 - codes 00, 01, 10 pick Manchester, Bi-Phase, NRZ; clears to 00.
// R7 - code 11 bypasses the buffer and sends a software data bit.
// R8 - the band bit picks 315 MHz at 0, 434 MHz at 1; soft reset clears it.
// R9 - the band bit also picks the divider for the 500 kHz reference clock.
// R10 - keying bit 1 picks on-off keying at 0, frequency shift at 1.
// R11 - enable bit 0 gates the 500 kHz reference clock to the timer.
// R12 - the buffer is 32 byte registers, lowest address holding bits 7 to 0.
// R13 - a one written to soft reset resets the block; it reads zero.
// R14 - buffer bytes are undefined after reset; soft reset leaves them.
module rtx_regs
    import rtx_pkg::*;
#(
    parameter int BUF_BYTES = 32,
    parameter int DIV_BAND0 = `RTX_XTAL_KHZ / `RTX_REF_KHZ,
    parameter int DIV_BAND1 = `RTX_XTAL_KHZ / `RTX_REF_KHZ
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   clk_en,
    input  wire logic [15:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [15:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   xtal_in,
    input  wire logic                   serial_bit,
    input  wire logic                   tx_on,
    output logic [12:0]                 space_freq_word,
    output logic [12:0]                 mark_freq_word,
    output logic                        band_select,
    output logic                        keying_select,
    output logic [1:0]                  encoding_select,
    output logic                        output_inversion,
    output logic                        ref_clock_out_en,
    output logic                        radio_soft_reset,
    output logic [BUF_BYTES*8-1:0]      tx_buffer_bit,
    output logic                        carrier_on,
    output logic [12:0]                 carrier_freq_word,
    output logic                        ref_clock_500k
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [12:0] space_reg;
    logic [12:0] mark_reg;
    logic        pol_reg;
    logic [1:0]  code_reg;
    logic        band_reg;
    logic        key_reg;
    logic        ref_clock_out_en_reg;
    logic        direct_reg;
    logic        srst_reg;
    logic [7:0]  buf_mem [BUF_BYTES];
    logic        aw_have_reg;
    logic        w_have_reg;
    logic [15:0] aw_addr_reg;
    logic [7:0]  w_byte_reg;
    logic        w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic        data_reg;
    logic        carrier_reg;
    logic [12:0] freq_reg;
    logic [2:0]  xtal_sync_reg;
    logic [7:0]  div_cnt_reg;
    logic        ref_reg;

    logic        wr_fire;
    logic [13:0] wr_idx;
    logic [13:0] rd_idx;
    logic        wr_ok;
    logic        rd_ok;
    logic [31:0] rd_word;
    logic        src_bit;
    logic [7:0]  half_div;

    // -----------------------------------------------------------------
    // axi write channel
    // -----------------------------------------------------------------
    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready  = !w_have_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    assign wr_idx  = aw_addr_reg[15:2];

    // address decode of the held write, word aligned
    always_comb begin
        if (aw_addr_reg[1:0] != 2'h0) begin
            wr_ok = 1'b0;
        end else if (wr_idx >= `RTX_IDX_DIRECT_CTRL
                     && wr_idx <= `RTX_IDX_BUF_LAST) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // address and data are caught in either order, then answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_addr_reg <= 16'h0000;
            w_byte_reg  <= 8'h00;
            w_strb_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RTX_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_byte_reg <= s_axi_wdata[7:0];
                w_strb_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_ok ? RTX_RESP_OKAY : RTX_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // configuration registers
    // -----------------------------------------------------------------
    // soft reset pulse, one cycle, never read back as one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            srst_reg <= 1'b0;
        end else if (clk_en) begin
            srst_reg <= wr_fire && w_strb_reg                   // see R13
                        && wr_idx == `RTX_IDX_SOFT_RESET
                        && w_byte_reg[`RTX_SOFT_RESET_BIT];
        end
    end

    // space word, polarity and encoding
    always_ff @(posedge aclk) begin
        if (!aresetn || (clk_en && srst_reg)) begin
            space_reg <= `RTX_FREQ_RESET;                       // see R2
            pol_reg   <= 1'b0;                                  // see R5
            code_reg  <= RTX_CODE_MANCHESTER;                   // see R6
        end else if (clk_en && wr_fire && w_strb_reg) begin
            if (wr_idx == `RTX_IDX_SPACE_HI) begin
                space_reg[12:5] <= w_byte_reg;                  // see R1
            end else if (wr_idx == `RTX_IDX_SPACE_LO) begin
                space_reg[4:0] <= w_byte_reg[`RTX_LO_FREQ_MSB:
                                             `RTX_LO_FREQ_LSB];
                pol_reg  <= w_byte_reg[`RTX_POL_BIT];
                code_reg <= w_byte_reg[`RTX_CODE_MSB:`RTX_CODE_LSB];
            end
        end
    end

    // mark word, band, keying and reference enable
    always_ff @(posedge aclk) begin
        if (!aresetn || (clk_en && srst_reg)) begin
            mark_reg  <= `RTX_FREQ_RESET;
            band_reg  <= 1'b0;                                  // see R8
            key_reg   <= 1'b0;                                  // see R10
            ref_clock_out_en_reg <= 1'b0;                                  // see R11
        end else if (clk_en && wr_fire && w_strb_reg) begin
            if (wr_idx == `RTX_IDX_MARK_HI) begin
                mark_reg[12:5] <= w_byte_reg;                   // see R3
            end else if (wr_idx == `RTX_IDX_MARK_LO) begin
                mark_reg[4:0] <= w_byte_reg[`RTX_LO_FREQ_MSB:
                                            `RTX_LO_FREQ_LSB];
                band_reg  <= w_byte_reg[`RTX_BAND_BIT];
                key_reg   <= w_byte_reg[`RTX_KEY_BIT];
                ref_clock_out_en_reg <= w_byte_reg[`RTX_REF_CLOCK_OUT_EN_BIT];
            end
        end
    end

    // software data bit for direct mode
    always_ff @(posedge aclk) begin
        if (!aresetn || (clk_en && srst_reg)) begin
            direct_reg <= 1'b0;
        end else if (clk_en && wr_fire && w_strb_reg
                     && wr_idx == `RTX_IDX_DIRECT_CTRL) begin
            direct_reg <= w_byte_reg[`RTX_DIRECT_BIT];          // see R7
        end
    end

    // transmit buffer, no reset at all
    always_ff @(posedge aclk) begin
        if (clk_en && wr_fire && w_strb_reg                     // see R14
            && wr_idx >= `RTX_IDX_BUF_FIRST
            && wr_idx <= `RTX_IDX_BUF_LAST) begin
            buf_mem[5'(wr_idx - `RTX_IDX_BUF_FIRST)] <= w_byte_reg;
        end
    end

    // lowest address holds the lowest buffer bits
    always_comb begin
        for (int i = 0; i < BUF_BYTES; i++) begin
            tx_buffer_bit[i*8 +: 8] = buf_mem[i];               // see R12
        end
    end

    // -----------------------------------------------------------------
    // axi read channel
    // -----------------------------------------------------------------
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign rd_idx = s_axi_araddr[15:2];

    // read decode, unmapped reads zero with an error
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = s_axi_araddr[1:0] == 2'h0;
        if (rd_idx == `RTX_IDX_DIRECT_CTRL) begin
            rd_word[0] = direct_reg;
        end else if (rd_idx == `RTX_IDX_SOFT_RESET) begin
            rd_word = 32'h0000_0000;                            // see R13
        end else if (rd_idx == `RTX_IDX_SPACE_HI) begin
            rd_word[7:0] = space_reg[12:5];
        end else if (rd_idx == `RTX_IDX_SPACE_LO) begin
            rd_word[7:0] = {space_reg[4:0], pol_reg, code_reg};
        end else if (rd_idx == `RTX_IDX_MARK_HI) begin
            rd_word[7:0] = mark_reg[12:5];
        end else if (rd_idx == `RTX_IDX_MARK_LO) begin
            rd_word[7:0] = {mark_reg[4:0], band_reg, key_reg, ref_clock_out_en_reg};
        end else if (rd_idx >= `RTX_IDX_BUF_FIRST
                     && rd_idx <= `RTX_IDX_BUF_LAST) begin
            rd_word[7:0] = buf_mem[5'(rd_idx - `RTX_IDX_BUF_FIRST)];
        end else begin
            rd_ok = 1'b0;
        end
        if (!rd_ok) begin
            rd_word = 32'h0000_0000;
        end
    end

    // one read at a time, answered the cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RTX_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_word;
                rresp_reg  <= rd_ok ? RTX_RESP_OKAY : RTX_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // modulation source and carrier selection
    // -----------------------------------------------------------------
    assign src_bit = (code_reg == RTX_CODE_DIRECT)              // see R7
                     ? direct_reg : serial_bit;

    // data bit, carrier gate and carrier word from flip-flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_reg    <= 1'b0;
            carrier_reg <= 1'b0;
            freq_reg    <= `RTX_FREQ_RESET;
        end else if (clk_en) begin
            data_reg <= src_bit ^ pol_reg;                      // see R5
            if (!tx_on) begin
                carrier_reg <= 1'b0;
            end else if (key_reg) begin
                carrier_reg <= 1'b1;                            // see R10
            end else begin
                carrier_reg <= src_bit ^ pol_reg;               // see R4
            end
            freq_reg <= (src_bit ^ pol_reg) ? mark_reg          // see R3
                                            : space_reg;        // see R1
        end
    end

    // -----------------------------------------------------------------
    // reference clock divider
    // -----------------------------------------------------------------
    // half period follows the band so the output stays at 500 kHz
    assign half_div = band_reg ? 8'(DIV_BAND1 / 2)              // see R9
                               : 8'(DIV_BAND0 / 2);

    // crystal pin through two flops, third stage for the edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xtal_sync_reg <= 3'h0;
        end else if (clk_en) begin
            xtal_sync_reg <= {xtal_sync_reg[1:0], xtal_in};
        end
    end

    // count crystal edges and toggle at each half period
    always_ff @(posedge aclk) begin
        if (!aresetn || (clk_en && (srst_reg || !ref_clock_out_en_reg))) begin
            div_cnt_reg <= 8'h00;
            ref_reg     <= 1'b0;                                // see R11
        end else if (clk_en && xtal_sync_reg[1] && !xtal_sync_reg[2]) begin
            if (div_cnt_reg >= half_div - 8'h01) begin
                div_cnt_reg <= 8'h00;
                ref_reg     <= !ref_reg;
            end else begin
                div_cnt_reg <= div_cnt_reg + 8'h01;
            end
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign space_freq_word   = space_reg;
    assign mark_freq_word    = mark_reg;
    assign band_select       = band_reg;
    assign keying_select     = key_reg;
    assign encoding_select   = code_reg;
    assign output_inversion  = pol_reg;
    assign ref_clock_out_en  = ref_clock_out_en_reg;
    assign radio_soft_reset  = srst_reg;
    assign carrier_on        = carrier_reg;
    assign carrier_freq_word = freq_reg;
    assign ref_clock_500k    = ref_reg;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_space_soft_clear: assert property (                       // see R2
        clk_en && srst_reg |=> space_reg == 13'h0000
    ) else $error("space word not cleared by soft reset");

    a_config_soft_clear: assert property (                      // see R8
        clk_en && srst_reg |=> !band_reg && !key_reg && !ref_clock_out_en_reg
                               && !pol_reg && code_reg == 2'h0
    ) else $error("configuration not cleared by soft reset");

    a_ook_zero_dark: assert property (                          // see R4
        clk_en && !key_reg && !(src_bit ^ pol_reg)
        |=> !carrier_on
    ) else $error("carrier emitted for a zero in on-off keying");

    a_fsk_carrier_on: assert property (                         // see R10
        clk_en && key_reg && tx_on |=> carrier_on
    ) else $error("carrier missing in frequency shift keying");

    a_direct_source: assert property (                          // see R7
        clk_en && code_reg == 2'h3
        |=> data_reg == ($past(direct_reg) ^ $past(pol_reg))
    ) else $error("direct mode not driven by software bit");

    a_freq_pick: assert property (                              // see R1
        clk_en |=> carrier_freq_word
                   == ($past(src_bit ^ pol_reg) ? $past(mark_reg)
                                                : $past(space_reg))
    ) else $error("carrier word does not follow the symbol");

    a_refclk_off: assert property (                             // see R11
        clk_en && !ref_clock_out_en_reg |=> !ref_clock_500k
    ) else $error("reference clock runs while disabled");

    a_softreg_reads_zero: assert property (                     // see R13
        clk_en && s_axi_arvalid && s_axi_arready
        && s_axi_araddr == {`RTX_IDX_SOFT_RESET, 2'b00}
        |=> s_axi_rdata == 32'h0000_0000
    ) else $error("soft reset control read back non-zero");

    a_bvalid_holds: assert property (
        bvalid_reg && !s_axi_bready |=> bvalid_reg
    ) else $error("write response dropped before taken");

    c_direct_mode: cover property (
        clk_en && code_reg == 2'h3 && tx_on
    );
    c_soft_reset: cover property (clk_en && srst_reg);
    c_fsk_high_band: cover property (clk_en && key_reg && band_reg);
    c_ref_toggle: cover property (ref_clock_out_en_reg ##1 $rose(ref_clock_500k));

endmodule : rtx_regs

// ### test/tb_rf_tx_pll_config_and_buffer.sv
/*
 * Self-checking bench for the radio transmitter register block.
 * Assumes: rtx_regs with default parameters, defines header on include path.
 */
`timescale 1ns/1ps
`include "rtx_defines.svh"

module tb_rf_tx_pll_config_and_buffer
    import rtx_pkg::*;
;
    // ----------------
    // signals and reference model state
    // ----------------
    logic               aclk = 1'b0;
    logic               aresetn = 1'b0;
    logic               clk_en = 1'b1;
    logic [15:0]        awaddr = 16'h0000, araddr = 16'h0000;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic               arvalid = 1'b0, rready = 1'b0;
    logic [31:0]        wdata = 32'h0000_0000;
    logic               xtal_in = 1'b0, serial_bit = 1'b0, tx_on = 1'b0;
    logic [1:0]         xdiv = 2'h0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [1:0]         bresp, rresp, encoding_select;
    logic [31:0]        rdata;
    logic [12:0]        space_freq_word, mark_freq_word, carrier_freq_word;
    logic               band_select, keying_select, output_inversion;
    logic               ref_clock_out_en, radio_soft_reset, carrier_on;
    logic               ref_clock_500k;
    logic [255:0]       tx_buffer_bit;
    int                 failures = 0;
    int                 checks = 0;
    int                 pulses = 0;
    logic [7:0]         m_cfg [0:3];
    logic [7:0]         m_buf [0:31];
    logic               m_dir;

    rtx_regs DUT (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .xtal_in(xtal_in),
        .serial_bit(serial_bit), .tx_on(tx_on),
        .space_freq_word(space_freq_word), .mark_freq_word(mark_freq_word),
        .band_select(band_select), .keying_select(keying_select),
        .encoding_select(encoding_select),
        .output_inversion(output_inversion),
        .ref_clock_out_en(ref_clock_out_en),
        .radio_soft_reset(radio_soft_reset), .tx_buffer_bit(tx_buffer_bit),
        .carrier_on(carrier_on), .carrier_freq_word(carrier_freq_word),
        .ref_clock_500k(ref_clock_500k)
    );

    // clock, crystal-rate stimulus and soft reset pulse counter
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        xdiv <= xdiv + 2'h1;
        xtal_in <= xdiv[1];
        if (radio_soft_reset === 1'b1) pulses <= pulses + 1;
    end

    // ----------------
    // compare, bus and model tasks
    // ----------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    // write one byte; release each channel at the edge that takes it
    task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d,
                          output logic [1:0] resp);
        bit ta, tw, done;
        done = 0;
        @(posedge aclk);
        awaddr <= {idx[13:0], 2'b00};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d,
                          output logic [1:0] resp);
        bit ta, done;
        done = 0;
        @(posedge aclk);
        araddr <= {idx[13:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ta = arvalid && arready;
            done = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : axi_rd

    // write through the bus and follow it in the model
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(idx, d, r);
        chk(r, RTX_RESP_OKAY);
        if (idx >= `RTX_IDX_SPACE_HI && idx <= `RTX_IDX_MARK_LO)
            m_cfg[idx - `RTX_IDX_SPACE_HI] = d;
        if (idx >= `RTX_IDX_BUF_FIRST && idx <= `RTX_IDX_BUF_LAST)
            m_buf[idx - `RTX_IDX_BUF_FIRST] = d;
        if (idx == `RTX_IDX_DIRECT_CTRL) m_dir = d[0];
        if (idx == `RTX_IDX_SOFT_RESET && d[0]) begin
            foreach (m_cfg[k]) m_cfg[k] = 8'h00;
            m_dir = 1'b0;
        end
    endtask : wr

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(idx, d, r);
        chk(r, RTX_RESP_OKAY);
        chk(d, {24'h00_0000, e});
    endtask : rd_chk

    // config ports and readback against the model
    task automatic chk_cfg;
        chk(space_freq_word, {m_cfg[0], m_cfg[1][7:3]});
        chk(output_inversion, m_cfg[1][2]);
        chk(encoding_select, m_cfg[1][1:0]);
        chk(mark_freq_word, {m_cfg[2], m_cfg[3][7:3]});
        chk(band_select, m_cfg[3][2]);
        chk(keying_select, m_cfg[3][1]);
        chk(ref_clock_out_en, m_cfg[3][0]);
        foreach (m_cfg[i]) rd_chk(`RTX_IDX_SPACE_HI + i, m_cfg[i]);
    endtask : chk_cfg

    task automatic chk_buf;
        for (int i = 0; i < 32; i++) begin
            chk(tx_buffer_bit[8*i +: 8], m_buf[i]);
            rd_chk(`RTX_IDX_BUF_FIRST + i, m_buf[i]);
        end
    endtask : chk_buf

    // count reference clock toggles over five of its half periods
    task automatic ref_chk(input logic [7:0] b, input int lo, input int hi);
        int   t;
        logic last;
        wr(`RTX_IDX_MARK_LO, b);
        t = 0;
        last = ref_clock_500k;
        repeat (520) begin
            @(negedge aclk);
            if (ref_clock_500k !== last) t++;
            last = ref_clock_500k;
        end
        chk(t >= lo && t <= hi, 1'b1);
    endtask : ref_chk

    task automatic final_report;
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // ----------------
    // main sequence and watchdog
    // ----------------
    initial begin
        logic [7:0]  v;
        logic [31:0] d;
        logic [1:0]  r;
        logic        db;
        void'($urandom(32'h0000_eade));
        foreach (m_cfg[k]) m_cfg[k] = 8'h00;
        m_dir = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        chk_cfg;
        for (int i = 0; i < 32; i++) wr(`RTX_IDX_BUF_FIRST + i, 8'($urandom));
        chk_buf;
        wr(`RTX_IDX_SPACE_HI, 8'($urandom));
        wr(`RTX_IDX_MARK_HI, 8'($urandom));
        // every encoding, inversion and keying against random data bits
        for (int i = 0; i < 24; i++) begin
            v = 8'($urandom);
            v[1:0] = 2'(i);
            wr(`RTX_IDX_SPACE_LO, v);
            wr(`RTX_IDX_MARK_LO, 8'($urandom));
            wr(`RTX_IDX_DIRECT_CTRL, 8'($urandom));
            serial_bit <= 1'($urandom);
            tx_on <= (i % 8 != 7);
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            db = ((m_cfg[1][1:0] == 2'h3) ? m_dir : serial_bit) ^ m_cfg[1][2];
            chk(carrier_on, m_cfg[3][1] ? tx_on : (tx_on & db));
            chk(carrier_freq_word, db ? {m_cfg[2], m_cfg[3][7:3]}
                                      : {m_cfg[0], m_cfg[1][7:3]});
        end
        chk_cfg;
        ref_chk(8'h00, 0, 0);
        ref_chk(8'h01, 4, 5);
        ref_chk(8'h05, 4, 5);
        axi_rd(16'h1830, d, r);
        chk(r, RTX_RESP_SLVERR);
        chk(d, 32'h0000_0000);
        axi_wr(16'h1830, 8'hff, r);
        chk(r, RTX_RESP_SLVERR);
        wr(`RTX_IDX_SOFT_RESET, 8'h00);
        chk(pulses, 0);
        wr(`RTX_IDX_SOFT_RESET, 8'h01);
        repeat (3) @(posedge aclk);
        chk(pulses, 1);
        chk_cfg;
        chk_buf;
        rd_chk(`RTX_IDX_SOFT_RESET, 8'h00);
        final_report;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        final_report;
    end
endmodule : tb_rf_tx_pll_config_and_buffer
